// ### logic/sfp_params.svh
// constants of the serial flash status and protection block
// Overview of operation
// (RQ1) accept spi clock mode 0 and mode 3
// (RQ2) sample input rising edge, shift output falling
// (RQ3) pages 256, sectors 4k, blocks 64k
// (RQ4) contiguous map, top 07ffffh or 03ffffh
// (RQ5) write permit command sets latch, reads 1
// (RQ6) latch clears: reset, revoke, cycle completion
// (RQ7) latch clear refuses status write, program, erase
// (RQ8) protect level guards region against program, erase
// (RQ9) lock bit set rejects status writes
// (RQ10) eight-block protect level decode
// (RQ11) four-block protect level decode
// (RQ12) status byte bit layout
// (RQ13) busy flag high during internal cycles
// (RQ14) four signals: clock, select, in, out
// (RQ15) one-byte opcode opens every transaction
// (RQ16) writes need whole bytes before select rises
// (RQ17) whole-array erase ignored when protect nonzero
// (RQ18) msb first, first bit on first rise
// (RQ19) reserved status bits read zero
// (RQ20) undocumented four-block codes protect everything
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// opcodes
`define SFP_OP_PERMIT   8'h06
`define SFP_OP_REVOKE   8'h04
`define SFP_OP_STW      8'h01
`define SFP_OP_RDSR     8'h05
`define SFP_OP_PROG     8'h02
`define SFP_OP_SECT     8'h20
`define SFP_OP_BLK      8'hd8
`define SFP_OP_CHIP_A   8'h60
`define SFP_OP_CHIP_B   8'hc7

// status byte fields
`define SFP_S_LOCK      7
`define SFP_S_BP_HI     4
`define SFP_S_BP_LO     2
`define SFP_S_WEL       1
`define SFP_S_BUSY      0

// delivery values of the nonvolatile bits
`define SFP_RST_LOCK    1'b0
`define SFP_RST_BP      3'h0

// geometry: 4k sectors, 64k blocks, block index lsb
`define SFP_SECT_MASK   24'hfff000
`define SFP_BLK_MASK    24'hff0000
`define SFP_BLK_LSB     16
`define SFP_TOP_BIG     24'h07ffff
`define SFP_TOP_SMALL   24'h03ffff

// byte counter limits
`define SFP_BYTES_ADDR  3'h4
`define SFP_BYTES_MAX   3'h7

// clock rate and internal cycle times
`define SFP_MCLK_MHZ    125
`define SFP_T_PROG_US   2000
`define SFP_T_SECT_US   180000
`define SFP_T_BLK_US    800000
`define SFP_T_CHIPB_US  6000000
`define SFP_T_CHIPS_US  3000000
`define SFP_T_STW_US    10000

`endif

// ### logic/sfp_pin_sync.sv
// two-stage synchroniser for the spi pins
`default_nettype none
module sfp_pin_sync #(
	parameter logic [2:0] RST_VAL = 3'h0
) (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic [2:0] d,
	output logic      [2:0] q
);
	logic [2:0] meta;       // first stage, read only by q
	logic [2:0] next_meta;
	logic [2:0] next_q;

	// next values: plain shift
	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	// both stages per bit
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule
`default_nettype wire

// ### logic/sfp_pkg.sv
// types of the serial flash status and protection block
`default_nettype none
package sfp_pkg;
	// internal cycle sequencer
	typedef enum logic {bs_idle, bs_run} sfp_busy_t;
	// kind of internal cycle started
	typedef enum logic [2:0] {
		op_stw, op_prog, op_sect, op_blk, op_chip
	} sfp_op_t;
endpackage
`default_nettype wire

// ### logic/sfp_top.sv
// spi front end, status byte and write protection of the serial flash
`include "sfp_params.svh"
`default_nettype none
module sfp_top #(
	parameter logic        BIG_PART = 1'b1,
	parameter logic [31:0] PROG_CYC = `SFP_T_PROG_US * `SFP_MCLK_MHZ,
	parameter logic [31:0] SECT_CYC = `SFP_T_SECT_US * `SFP_MCLK_MHZ,
	parameter logic [31:0] BLK_CYC  = `SFP_T_BLK_US * `SFP_MCLK_MHZ,
	parameter logic [31:0] CHIPB_CYC = `SFP_T_CHIPB_US * `SFP_MCLK_MHZ,
	parameter logic [31:0] CHIPS_CYC = `SFP_T_CHIPS_US * `SFP_MCLK_MHZ,
	parameter logic [31:0] STW_CYC  = `SFP_T_STW_US * `SFP_MCLK_MHZ
) (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       sclk,
	input  wire logic       cs_b,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	output logic            op_go,
	output sfp_pkg::sfp_op_t op_kind,
	output logic [23:0]     op_addr,
	output logic [7:0]      prog_byte,
	output logic            prog_byte_valid,
	output logic [7:0]      status
);
	logic [2:0]  pins_s;     // synced sclk, cs_b, si
	logic        sclk_s;
	logic        cs_s;
	logic        si_s;
	logic        sclk_d;     // previous synced clock
	logic        cs_d;       // previous synced select
	logic [2:0]  bit_cnt;
	logic [2:0]  byte_cnt;   // saturates, enough to tell lengths
	logic [7:0]  sh_in;
	logic [7:0]  opcode;
	logic [23:0] addr;
	logic [7:0]  data_b;     // first byte after opcode
	logic [7:0]  so_sh;
	logic        lock;       // status_lock_bit
	logic [2:0]  bp;         // protect_level_top..low
	logic        write_permit_latch;        // write_permit_latch
	sfp_pkg::sfp_busy_t bstate;
	logic [31:0] bcnt;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_start;
	logic        cs_end;
	logic        busy;       // busy_flag
	logic [7:0]  byte_in;
	logic [23:0] am;         // address folded into the part
	logic [31:0] chip_cyc;

	logic        next_sclk_d, next_cs_d, next_lock, next_wel;
	logic [2:0]  next_bit_cnt, next_byte_cnt, next_bp;
	logic [7:0]  next_sh_in, next_opcode, next_data_b, next_so_sh;
	logic [23:0] next_addr, next_op_addr;
	logic [31:0] next_bcnt;
	logic [7:0]  next_prog_byte;
	logic        next_prog_byte_valid, next_op_go;
	sfp_pkg::sfp_busy_t next_bstate;
	sfp_pkg::sfp_op_t   next_op_kind;

	// is the block holding address a covered by protect level lv
	function automatic logic blk_protected(input logic [23:0] a,
		input logic [2:0] lv, input logic big);
		logic [2:0] b;
		b = a[`SFP_BLK_LSB +: 3];
		if (big) begin
			unique case (lv) // [RQ10]
				3'h0: blk_protected = 1'b0;
				3'h1: blk_protected = (b == 3'h7);
				3'h2: blk_protected = (b >= 3'h6);
				3'h3: blk_protected = (b >= 3'h4);
				default: blk_protected = 1'b1;
			endcase
		end else begin
			unique case (lv) // [RQ11]
				3'h0: blk_protected = 1'b0;
				3'h1: blk_protected = (b[1:0] == 2'h3);
				3'h2: blk_protected = (b[1:0] >= 2'h2);
				default: blk_protected = 1'b1; // [RQ20]
			endcase
		end
	endfunction

	// pins come from the host's domain
	sfp_pin_sync #(
		.RST_VAL (3'h2)
	) u_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.d     ({sclk, cs_b, si}),
		.q     (pins_s)
	);

	// edge finding; both idle levels of sclk work the same [RQ1]
	assign sclk_s    = pins_s[2];
	assign cs_s      = pins_s[1];
	assign si_s      = pins_s[0];
	assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
	assign cs_start  = cs_d & ~cs_s;
	assign cs_end    = ~cs_d & cs_s;
	assign busy      = (bstate == sfp_pkg::bs_run); // [RQ13]
	assign byte_in   = {sh_in[6:0], si_s}; // msb first [RQ18]
	assign am        = addr & (BIG_PART ? `SFP_TOP_BIG
		: `SFP_TOP_SMALL); // [RQ4]
	assign chip_cyc  = BIG_PART ? CHIPB_CYC : CHIPS_CYC;
	// reserved bits tied low [RQ19]
	assign status    = {lock, 2'b00, bp, write_permit_latch, busy}; // [RQ12]
	assign so        = so_sh[7];
	assign so_oe     = ~cs_s; // [RQ14]

	// next state of the whole block
	always_comb begin
		next_sclk_d   = sclk_s;
		next_cs_d     = cs_s;
		next_bit_cnt  = bit_cnt;
		next_byte_cnt = byte_cnt;
		next_sh_in    = sh_in;
		next_opcode   = opcode;
		next_addr     = addr;
		next_data_b   = data_b;
		next_so_sh    = so_sh;
		next_lock     = lock;
		next_bp       = bp;
		next_wel      = write_permit_latch;
		next_bstate   = bstate;
		next_bcnt     = bcnt;
		next_op_go    = 1'b0;
		next_op_kind  = op_kind;
		next_op_addr  = op_addr;
		next_prog_byte       = prog_byte;
		next_prog_byte_valid = 1'b0;
		// new frame: counting restarts at the opcode [RQ15]
		if (cs_start) begin
			next_bit_cnt  = 3'h0;
			next_byte_cnt = 3'h0;
		end
		// input bits on rising edges [RQ2]
		if (sclk_rise) begin
			next_sh_in   = byte_in;
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				if (byte_cnt != `SFP_BYTES_MAX)
					next_byte_cnt = byte_cnt + 3'h1;
				if (byte_cnt == 3'h0)
					next_opcode = byte_in; // [RQ15]
				if (byte_cnt == 3'h1)
					next_data_b = byte_in;
				if (byte_cnt != 3'h0 && byte_cnt < `SFP_BYTES_ADDR)
					next_addr = {addr[15:0], byte_in};
				// page data passes out while latch set and idle, protected block or not
				if (byte_cnt >= `SFP_BYTES_ADDR && write_permit_latch && !busy &&
					opcode == `SFP_OP_PROG) begin
					next_prog_byte       = byte_in;
					next_prog_byte_valid = 1'b1;
				end
			end
		end
		// output bits on falling edges, status reloaded per byte [RQ2]
		if (sclk_fall) begin
			if (bit_cnt == 3'h0 && byte_cnt != 3'h0 &&
				opcode == `SFP_OP_RDSR)
				next_so_sh = status;
			else
				next_so_sh = {so_sh[6:0], 1'b0};
		end
		// internal cycle timer
		unique case (bstate)
			sfp_pkg::bs_idle: begin
				// frames ending mid-byte do nothing [RQ16]
				if (cs_end && bit_cnt == 3'h0 && byte_cnt != 3'h0) begin
					case (opcode)
						`SFP_OP_PERMIT: begin
							if (byte_cnt == 3'h1)
								next_wel = 1'b1; // [RQ5]
						end
						`SFP_OP_REVOKE: begin
							if (byte_cnt == 3'h1)
								next_wel = 1'b0; // [RQ6]
						end
						`SFP_OP_STW: begin
							// locked or unpermitted writes dropped [RQ7] [RQ9]
							if (write_permit_latch && !lock && byte_cnt == 3'h2) begin
								next_lock    = data_b[`SFP_S_LOCK];
								next_bp      = data_b[`SFP_S_BP_HI:`SFP_S_BP_LO];
								next_op_kind = sfp_pkg::op_stw;
								next_bcnt    = STW_CYC - 32'h1;
								next_bstate  = sfp_pkg::bs_run;
								next_op_go   = 1'b1;
							end
						end
						`SFP_OP_PROG: begin
							if (write_permit_latch && byte_cnt > `SFP_BYTES_ADDR &&
								!blk_protected(am, bp, BIG_PART)) begin // [RQ7] [RQ8]
								next_op_kind = sfp_pkg::op_prog;
								next_op_addr = am;
								next_bcnt    = PROG_CYC - 32'h1;
								next_bstate  = sfp_pkg::bs_run;
								next_op_go   = 1'b1;
							end
						end
						`SFP_OP_SECT: begin
							if (write_permit_latch && byte_cnt == `SFP_BYTES_ADDR &&
								!blk_protected(am, bp, BIG_PART)) begin // [RQ8]
								next_op_kind = sfp_pkg::op_sect;
								next_op_addr = am & `SFP_SECT_MASK; // [RQ3]
								next_bcnt    = SECT_CYC - 32'h1;
								next_bstate  = sfp_pkg::bs_run;
								next_op_go   = 1'b1;
							end
						end
						`SFP_OP_BLK: begin
							if (write_permit_latch && byte_cnt == `SFP_BYTES_ADDR &&
								!blk_protected(am, bp, BIG_PART)) begin // [RQ8]
								next_op_kind = sfp_pkg::op_blk;
								next_op_addr = am & `SFP_BLK_MASK; // [RQ3]
								next_bcnt    = BLK_CYC - 32'h1;
								next_bstate  = sfp_pkg::bs_run;
								next_op_go   = 1'b1;
							end
						end
						`SFP_OP_CHIP_A, `SFP_OP_CHIP_B: begin
							if (write_permit_latch && byte_cnt == 3'h1 && bp == 3'h0) begin // [RQ17]
								next_op_kind = sfp_pkg::op_chip;
								next_op_addr = 24'h000000;
								next_bcnt    = chip_cyc - 32'h1;
								next_bstate  = sfp_pkg::bs_run;
								next_op_go   = 1'b1;
							end
						end
						default: ;
					endcase
				end
			end
			sfp_pkg::bs_run: begin
				// commands other than status read are dropped until idle
				if (bcnt == 32'h0) begin
					next_bstate = sfp_pkg::bs_idle;
					next_wel    = 1'b0; // [RQ6]
				end else begin
					next_bcnt = bcnt - 32'h1;
				end
			end
		endcase
	end

	// registers; lock and protect level start at delivery values
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_d   <= 1'b0;
			cs_d     <= 1'b1;
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			sh_in    <= 8'h00;
			opcode   <= 8'h00;
			addr     <= 24'h000000;
			data_b   <= 8'h00;
			so_sh    <= 8'h00;
			lock     <= `SFP_RST_LOCK;
			bp       <= `SFP_RST_BP;
			write_permit_latch      <= 1'b0; // power-up clears [RQ6]
			bstate   <= sfp_pkg::bs_idle;
			bcnt     <= 32'h0;
			op_go    <= 1'b0;
			op_kind  <= sfp_pkg::op_stw;
			op_addr  <= 24'h000000;
			prog_byte       <= 8'h00;
			prog_byte_valid <= 1'b0;
		end else begin
			sclk_d   <= next_sclk_d;
			cs_d     <= next_cs_d;
			bit_cnt  <= next_bit_cnt;
			byte_cnt <= next_byte_cnt;
			sh_in    <= next_sh_in;
			opcode   <= next_opcode;
			addr     <= next_addr;
			data_b   <= next_data_b;
			so_sh    <= next_so_sh;
			lock     <= next_lock;
			bp       <= next_bp;
			write_permit_latch      <= next_wel;
			bstate   <= next_bstate;
			bcnt     <= next_bcnt;
			op_go    <= next_op_go;
			op_kind  <= next_op_kind;
			op_addr  <= next_op_addr;
			prog_byte       <= next_prog_byte;
			prog_byte_valid <= next_prog_byte_valid;
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_PERMIT_SETS: assert property ( // [RQ5]
		cs_end && !busy && bit_cnt == 3'h0 && byte_cnt == 3'h1 &&
		opcode == `SFP_OP_PERMIT |=> write_permit_latch && status[`SFP_S_WEL])
		else $error("write permit did not set latch");
	AST_REVOKE_CLEARS: assert property ( // [RQ6]
		cs_end && !busy && bit_cnt == 3'h0 && byte_cnt == 3'h1 &&
		opcode == `SFP_OP_REVOKE |=> !write_permit_latch)
		else $error("write revoke did not clear latch");
	AST_DONE_CLEARS: assert property ( // [RQ6]
		busy && bcnt == 32'h0 |=> !write_permit_latch && !busy)
		else $error("cycle end left latch or busy set");
	AST_NO_PERMIT_NO_CYCLE: assert property ( // [RQ7]
		!write_permit_latch && !busy |=> !busy)
		else $error("cycle started without write permit");
	AST_LOCK_FREEZES: assert property ( // [RQ9]
		lock |=> lock && $stable(bp))
		else $error("locked status changed");
	AST_CHIP_NEEDS_ZERO: assert property ( // [RQ17]
		op_go && op_kind == sfp_pkg::op_chip |-> $past(bp) == 3'h0)
		else $error("whole erase started while protected");
	AST_PROT_REGION: assert property ( // [RQ8]
		op_go && (op_kind == sfp_pkg::op_prog ||
		op_kind == sfp_pkg::op_sect || op_kind == sfp_pkg::op_blk) |->
		!blk_protected(op_addr, bp, BIG_PART))
		else $error("protected region modified");
	AST_SO_ON_FALL: assert property ( // [RQ2]
		$changed(so) |-> $past(sclk_fall))
		else $error("output moved off a falling edge");
	AST_PARTIAL_IGNORED: assert property ( // [RQ16]
		cs_end && !busy && bit_cnt != 3'h0 |=> $stable(write_permit_latch) && !busy)
		else $error("partial byte frame executed");
	AST_BUSY_WHILE_RUN: assert property ( // [RQ13]
		op_go |-> status[`SFP_S_BUSY] ##1 status[`SFP_S_BUSY] ||
		$past(bcnt) == 32'h0)
		else $error("busy flag not shown during cycle");

	COV_PERMIT: cover property ($rose(write_permit_latch));
	COV_STW: cover property (op_go && op_kind == sfp_pkg::op_stw);
	COV_CHIP: cover property (op_go && op_kind == sfp_pkg::op_chip);
	COV_RDSR: cover property (sclk_fall && bit_cnt == 3'h0 &&
		byte_cnt != 3'h0 && opcode == `SFP_OP_RDSR);
endmodule
`default_nettype wire

// ### verification/sfp_host.sv
// spi host model that drives the flash pins
`default_nettype none
module sfp_host (
	input  wire logic mclk,
	output var logic  sclk,
	output var logic  cs_b,
	output var logic  si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;
	// four pins only, idle and deselected at start
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		si = 1'b0;
	end
	// half a 64 ns link period; pins move by nba on the mclk edge
	task automatic half();
		repeat (4) @(posedge mclk);
	endtask
	// one frame of nb bits; clock idles high in mode 3
	// clock stands still outside the frame
	task automatic frame(input logic m3, input int nb,
		input logic [39:0] d, output logic [7:0] rx);
		rx = 8'h00;
		sclk <= m3;
		half();
		cs_b <= 1'b0;
		half();
		for (int i = nb - 1; i >= 0; i--) begin
			sclk <= 1'b0;
			si <= d[i]; // msb first, opcode leads
			half();
			rx = {rx[6:0], so}; // taken just before the rise
			sclk <= 1'b1;
			half();
		end
		sclk <= m3;
		half();
		cs_b <= 1'b1; // raised after nb bits only
		si <= ~si; // released line shows no stale bit
		half();
	endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench of the flash status and protection block
`include "sfp_params.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CYC = 32'h14; // short internal cycles
	logic             mclk;
	logic             rst_b;
	logic             sclk;
	logic             cs_b;
	logic             si;
	logic             so;
	logic             so_oe;
	logic             op_go;
	sfp_pkg::sfp_op_t op_kind;
	logic [23:0]      op_addr;
	logic [7:0]       prog_byte;
	logic             prog_byte_valid;
	logic [7:0]       status;
	logic             op_go_s;    // four-block copy
	logic [23:0]      op_addr_s;
	logic [7:0]       status_s;
	logic [7:0]       rx;
	int               err_total = 0;
	int               n_compared = 0;
	int               n_go = 0;
	int               n_go_s = 0;
	int               n_pb = 0;
	int               n_oe = 0;
	int               seed = 54718;

	sfp_top #(
		.BIG_PART (1'b1),
		.PROG_CYC (CYC),
		.SECT_CYC (CYC),
		.BLK_CYC  (CYC),
		.CHIPB_CYC(CYC),
		.CHIPS_CYC(CYC),
		.STW_CYC  (CYC)
	) dut (
		.mclk           (mclk),
		.rst_b          (rst_b),
		.sclk           (sclk),
		.cs_b           (cs_b),
		.si             (si),
		.so             (so),
		.so_oe          (so_oe),
		.op_go          (op_go),
		.op_kind        (op_kind),
		.op_addr        (op_addr),
		.prog_byte      (prog_byte),
		.prog_byte_valid(prog_byte_valid),
		.status         (status)
	);

	// four-block part on the same pins
	sfp_top #(
		.BIG_PART (1'b0),
		.PROG_CYC (CYC),
		.SECT_CYC (CYC),
		.BLK_CYC  (CYC),
		.CHIPB_CYC(CYC),
		.CHIPS_CYC(CYC),
		.STW_CYC  (CYC)
	) dut_small (
		.mclk           (mclk),
		.rst_b          (rst_b),
		.sclk           (sclk),
		.cs_b           (cs_b),
		.si             (si),
		.so             (),
		.so_oe          (),
		.op_go          (op_go_s),
		.op_kind        (),
		.op_addr        (op_addr_s),
		.prog_byte      (),
		.prog_byte_valid(),
		.status         (status_s)
	);

	sfp_host host (
		.mclk(mclk),
		.sclk(sclk),
		.cs_b(cs_b),
		.si  (si),
		.so  (so)
	);

	// 125 mhz system clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// counts started cycles, page strobes and driven cycles
	always @(posedge mclk) begin
		if (op_go === 1'b1)
			n_go <= n_go + 1;
		if (op_go_s === 1'b1)
			n_go_s <= n_go_s + 1;
		if (prog_byte_valid === 1'b1)
			n_pb <= n_pb + 1;
		if (so_oe === 1'b1)
			n_oe <= n_oe + 1;
	end

	// protected blocks of the eight-block part
	function automatic logic prot(input logic [2:0] c,
		input logic [2:0] b);
		case (c)
			3'h0: prot = 1'b0;
			3'h1: prot = (b == 3'h7);
			3'h2: prot = (b >= 3'h6);
			3'h3: prot = (b >= 3'h4);
			default: prot = 1'b1;
		endcase
	endfunction

	// protected blocks of the four-block part
	function automatic logic prot_s(input logic [2:0] c,
		input logic [1:0] b);
		case (c)
			3'h0: prot_s = 1'b0;
			3'h1: prot_s = (b == 2'h3);
			3'h2: prot_s = (b >= 2'h2);
			default: prot_s = 1'b1; // level 3 and top-bit codes: all
		endcase
	endfunction

	// cycle kind each array command should start
	function automatic sfp_pkg::sfp_op_t kind_of(input logic [1:0] k);
		case (k)
			2'h0: kind_of = sfp_pkg::op_prog;
			2'h1: kind_of = sfp_pkg::op_sect;
			default: kind_of = sfp_pkg::op_blk;
		endcase
	endfunction

	task automatic check(input logic [31:0] seen,
		input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t %s: saw %h want %h", $time, what,
				seen, exp);
		end
	endtask

	// one frame in a random clock mode, then let the end settle
	task automatic cmd(input int nb, input logic [39:0] d);
		logic m3;
		m3 = 1'($random(seed));
		host.frame(m3, nb, d, rx);
		repeat (8) @(posedge mclk);
	endtask

	// bounded wait for the busy flag to drop
	task automatic wait_idle();
		for (int k = 0; k < 200 && (status[0] !== 1'b0 ||
			status_s[0] !== 1'b0); k++)
			@(posedge mclk);
	endtask

	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	initial begin
		#400000;
		err_total++;
		summarize();
	end

	initial begin
		logic [7:0]  d;
		logic [7:0]  pb;
		logic [2:0]  b;
		logic [1:0]  kd;
		logic [23:0] a;
		logic [23:0] ea;
		logic        ok;
		int          g;
		int          gs;
		int          gp;
		logic        ok_s;
		logic [23:0] es;
		rst_b = 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		check(status, 8'h00, "reset");
		check(status_s, 8'h00, "reset small");
		cmd(16, 40'h011c);
		check(n_go, 0, "unpermitted write");
		check(status, 8'h00, "unpermitted status");
		g = n_oe;
		cmd(8, 40'h06);
		check(status, 8'h02, "permit");
		// select low for 2 + 2*8 half periods of 4 cycles
		check(n_oe - g, 72, "output enable span");
		// status read in both clock modes
		for (int m = 0; m < 2; m++) begin
			host.frame(1'(m), 16, 40'h0500, rx);
			repeat (8) @(posedge mclk);
			check(rx, 8'h02, "status read");
			check(so_oe, 1'b0, "output released");
		end
		cmd(7, 40'h02); // revoke cut one bit short
		check(status, 8'h02, "short frame");
		cmd(8, 40'h04);
		check(status, 8'h00, "revoke");
		// every protect level, one array op and a whole erase each
		for (int c = 0; c < 8; c++) begin
			d = 8'($random(seed));
			d = {1'b0, d[6:5], 3'(c), d[1:0]};
			cmd(8, 40'h06);
			g = n_go;
			gs = n_go_s;
			cmd(16, {24'h000001, d});
			check(n_go, g + 1, "status write");
			check(n_go_s, gs + 1, "status write small");
			check(op_kind, sfp_pkg::op_stw, "status kind");
			check(status[0], 1'b1, "busy");
			wait_idle();
			check(status, {3'h0, d[4:2], 2'h0}, "level");
			check(status_s, {3'h0, d[4:2], 2'h0}, "level small");
			a = 24'($random(seed));
			b = a[18:16];
			pb = 8'($random(seed));
			kd = 2'($unsigned($random(seed)) % 3);
			cmd(8, 40'h06);
			g = n_go;
			gs = n_go_s;
			gp = n_pb;
			ea = a & `SFP_TOP_BIG;
			es = a & `SFP_TOP_SMALL;
			if (kd == 2'h0)
				cmd(40, {8'h02, a, pb});
			else if (kd == 2'h1)
				cmd(32, {8'h20, a});
			else
				cmd(32, {8'hd8, a});
			if (kd == 2'h1) begin
				ea = ea & `SFP_SECT_MASK;
				es = es & `SFP_SECT_MASK;
			end
			if (kd == 2'h2) begin
				ea = ea & `SFP_BLK_MASK;
				es = es & `SFP_BLK_MASK;
			end
			ok = !prot(3'(c), b);
			ok_s = !prot_s(3'(c), b[1:0]);
			check(n_go, g + ok, "guarded op");
			check(n_go_s, gs + ok_s, "guarded op small");
			// one strobe per whole data byte, protected or not
			check(n_pb, gp + (kd == 2'h0), "page strobe");
			if (ok)
				check(op_addr, ea, "op address");
			if (ok)
				check(op_kind, kind_of(kd), "op kind");
			if (ok_s)
				check(op_addr_s, es, "op address small");
			if (ok && kd == 2'h0)
				check(prog_byte, pb, "page byte");
			wait_idle();
			check(status[1], !ok, "latch after op");
			check(status_s[1], !ok_s, "latch small");
			cmd(8, 40'h06);
			g = n_go;
			gs = n_go_s;
			cmd(8, $random(seed) & 1 ? 40'h60 : 40'hc7);
			check(n_go, g + (c == 0), "whole erase");
			check(n_go_s, gs + (c == 0), "whole erase small");
			wait_idle();
			cmd(8, 40'h04);
		end
		// lock the status byte, then try to rewrite it
		cmd(8, 40'h06);
		cmd(16, 40'h0180);
		wait_idle();
		check(status, 8'h80, "lock set");
		cmd(8, 40'h06);
		g = n_go;
		cmd(16, 40'h011c);
		check(n_go, g, "locked write");
		check(status, 8'h82, "locked status");
		check(status_s, 8'h82, "locked status small");
		// power cycle in mid-run: delivery state comes back
		rst_b <= 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		check(status, 8'h00, "second reset");
		cmd(8, 40'h06);
		check(status, 8'h02, "permit after reset");
		summarize();
	end
endmodule
`default_nettype wire
